/* tb_usc_serial_ctrl.sv */
// self-checking bench of the serial control block
`timescale 1ns/1ps
`default_nettype none
module tb_usc_serial_ctrl;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] v;
  logic [15:0] lf = 16'h3FE3;
  logic [7:0] sa, mk, b;
  logic [7:0] ra[8] = '{8'h98, 8'hA9, 8'hB9, 8'hC0, 8'hC4, 8'hC8, 8'hD0, 8'h10};
  wire [31:0] hrdata;
  wire hready, hresp, tx9, irq, ren, fdet, t8, ts, rl, rdn, r9, rs;
  wire [1:0] mode;
  wire [7:0] rb;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  usc_serial_ctrl u_usc_serial_ctrl (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .tx_bit8_end(t8),
    .tx_stop_start(ts), .tx_ninth_bit_out(tx9), .rx_last_data(rl), .rx_done(rdn),
    .rx_byte(rb), .rx_bit9(r9), .rx_stop(rs), .serial_mode(mode), .rx_enable(ren),
    .framing_detect(fdet), .irq(irq));
  usc_stn u_usc_stn (.clk(clk), .tx_bit8_end(t8), .tx_stop_start(ts),
    .rx_last_data(rl), .rx_done(rdn), .rx_byte(rb), .rx_bit9(r9), .rx_stop(rs));
  always #5 clk = ~clk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // accepted as given address or as broadcast address
  function automatic logic hit(input logic [7:0] x, input logic [7:0] a, input logic [7:0] m);
    return ((x ^ a) & m) == 8'h0 || ((x ^ (a | m)) & (a | m)) == 8'h0;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // upper data bits carry junk: only the low byte may count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {a, 2'b00};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {~d, ~d, ~d, d};
    do @(posedge clk); while (hready !== 1'b1);
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h0);
    chk(v, {24'h0, e});
  endtask
  task automatic rx(input logic [7:0] x, input logic b9, input logic st);
    u_usc_stn.frame(x, b9, st);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h0);
    chk({26'h0, mode, ren, fdet, irq, tx9}, 32'h0);
    lf = nx(lf);
    wr(8'hA9, lf[7:0]);
    rd(8'hA9, lf[7:0]);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h0);
    for (int m = 0; m < 4; m++) begin
      wr(8'h98, {m[1:0], 6'h18});
      chk({29'h0, mode, tx9}, {29'h0, m[1:0], m[1]});
      rd(8'h98, {m[1:0], 6'h18});
    end
    for (int m = 0; m < 4; m++) begin
      lf = nx(lf);
      wr(8'h98, {m[1:0], 6'h14});
      rx(lf[7:0], lf[8], lf[9]);
      b = m == 0 ? 8'h04 : {5'h0, m == 1 ? lf[9] : lf[8], 2'h0};
      rd(8'h98, {m[1:0], 6'h11} | b);
      rd(8'hD0, lf[7:0]);
    end
    wr(8'h98, 8'hC0);
    rx(8'hA5, 1'b1, 1'b1);
    rd(8'h98, 8'hC0);
    wr(8'h98, 8'hD0);
    wr(8'hC0, 8'h01);
    wr(8'hC8, 8'h07);
    rx(8'h3C, 1'b0, 1'b0);
    rd(8'h98, 8'hD1);
    rd(8'hC4, 8'h06);
    chk({31'h0, irq}, 32'h1);
    rx(8'hC3, 1'b1, 1'b1);
    rd(8'h98, 8'hD5);
    wr(8'h98, 8'h50);
    rd(8'h98, 8'h50);
    chk({30'h0, mode}, 32'h3);
    wr(8'hC0, 8'h00);
    rd(8'h98, 8'hD0);
    wr(8'hCC, 8'h07);
    chk({31'h0, irq}, 32'h0);
    wr(8'h98, 8'h10);
    u_usc_stn.tx_end(1'b0);
    repeat (12) @(posedge clk);
    rd(8'h98, 8'h12);
    chk({31'h0, irq}, 32'h1);
    wr(8'hC8, 8'h06);
    chk({31'h0, irq}, 32'h0);
    wr(8'hCC, 8'h01);
    wr(8'hC8, 8'h07);
    chk({31'h0, irq}, 32'h0);
    wr(8'h98, 8'h50);
    u_usc_stn.tx_end(1'b0);
    rd(8'h98, 8'h50);
    u_usc_stn.tx_end(1'b1);
    rd(8'h98, 8'h52);
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      sa = i < 2 ? 8'h0 : lf[7:0];
      mk = i < 2 ? 8'h0 : lf[15:8];
      b = i[0] ? sa | mk : lf[11:4];
      wr(8'hA9, sa);
      wr(8'hB9, mk);
      wr(8'h98, 8'hF0);
      rx(b, i != 4, 1'b1);
      rd(8'h98, (i != 4 && hit(b, sa, mk)) ? 8'hF5 : 8'hF0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire

/* usc_addr_match.v */
// automatic address recognition: given and broadcast address compare
`timescale 1ns/1ps
`default_nettype none
module usc_addr_match (
  // address registers
  input wire [7:0] slave_address,
  input wire [7:0] slave_address_mask,
  // received byte
  input wire [7:0] rx_byte,
  // result
  output wire match
);
  wire [7:0] bcast;
  wire given_hit;
  wire bcast_hit;
  // zero bits of the broadcast are don't-care
  assign bcast = slave_address | slave_address_mask;
  assign given_hit = ((rx_byte ^ slave_address) & slave_address_mask) == 8'h00;
  assign bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;
  // both registers zero: every bit don't-care, any address accepted
  assign match = given_hit | bcast_hit;
endmodule
`default_nettype wire

/* usc_map.vh */
// register map, field positions and reset values of the serial control block
`ifndef USC_MAP_VH
`define USC_MAP_VH
`define USC_OFF_CTRL 8'h98
`define USC_OFF_SLAVE_ADDRESS 8'hA9
`define USC_OFF_SMASK 8'hB9
`define USC_OFF_FACC 8'hC0
`define USC_OFF_IRQ_STAT 8'hC4
`define USC_OFF_IRQ_EN 8'hC8
`define USC_OFF_IRQ_CLR 8'hCC
`define USC_OFF_RXDATA 8'hD0
`define USC_BIT_TOP 7
`define USC_BIT_MODE_LO 6
`define USC_BIT_MP 5
`define USC_BIT_REN 4
`define USC_BIT_TB8 3
`define USC_BIT_RB8 2
`define USC_BIT_TI 1
`define USC_BIT_RI 0
`define USC_RST_CTRL 8'h00
`define USC_RST_SLAVE_ADDRESS 8'h00
`define USC_RST_SMASK 8'h00
`define USC_IRQ_W 3
`endif

/* usc_monitor.sv */
// port assertions of the serial control block
`timescale 1ns/1ps
`default_nettype none
module usc_monitor (
  // clock and reset
  input wire clk,
  input wire resetn,
  // bus
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // serial side
  input wire tx_ninth_bit_out,
  input wire [1:0] serial_mode,
  input wire rx_enable,
  input wire framing_detect,
  input wire irq
);
  wire ap = hsel && hready && htrans[1];
  wire rd = ap && !hwrite;
  wire wc = ap && hwrite && haddr[9:2] == 8'h98;
  wire wa = ap && hwrite && haddr[9:2] == 8'hC0;
  wire wi = ap && hwrite && (haddr[9:2] == 8'hC8 || haddr[9:2] == 8'hCC);
  // write history: a register may take up to three edges to show a write
  logic [2:0] wcp, wap, wip;
  always @(posedge clk) begin
    wcp <= {wcp[1:0], wc};
    wap <= {wap[1:0], wa};
    wip <= {wip[1:0], wi};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_reset_clear: assert property (disable iff (1'b0)
    !resetn |=> hrdata == 32'h0 && !irq && serial_mode == 2'h0 && !rx_enable && !framing_detect)
    else $error("outputs not cleared by reset");
  a_ninth_mode: assert property (tx_ninth_bit_out |-> serial_mode[1])
    else $error("ninth bit sent outside nine-bit modes");
  a_mode_by_write: assert property ($changed(serial_mode) |-> wcp != 3'h0)
    else $error("mode changed without a control write");
  a_ren_by_write: assert property ($changed(rx_enable) |-> wcp != 3'h0)
    else $error("receive enable changed without a control write");
  a_access_by_write: assert property ($changed(framing_detect) |-> wap != 3'h0)
    else $error("access select changed without its write");
  a_irq_drop: assert property ($fell(irq) |-> wip != 3'h0)
    else $error("interrupt dropped without software action");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd))
    else $error("read data changed without a read");
endmodule
bind usc_serial_ctrl usc_monitor u_usc_monitor (.clk(clk), .resetn(resetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .tx_ninth_bit_out(tx_ninth_bit_out),
  .serial_mode(serial_mode), .rx_enable(rx_enable), .framing_detect(framing_detect), .irq(irq));
`default_nettype wire

/* usc_rx_frame.v */
// receive frame capture: ninth bit, stop bit check and event pulses
`timescale 1ns/1ps
`default_nettype none
module usc_rx_frame (
  // clock and reset
  input wire clk,
  input wire resetn,
  // frame from the shift engine
  input wire rx_done,
  input wire [7:0] rx_byte,
  input wire rx_bit9,
  input wire rx_stop,
  // configuration
  input wire [1:0] mode,
  input wire multiproc_enable,
  input wire addr_match,
  // results, registered
  output reg rx_accept_q,
  output reg rx_bad_stop_q,
  output reg rx_load9_q,
  output reg rx_val9_q,
  output reg [7:0] rx_data_q
);
  reg accept_d;
  reg load9_d;
  reg val9_d;
  always @* begin
    accept_d = 1'b1;
    load9_d = 1'b0;
    val9_d = 1'b0;
    case (mode)
      2'b00: begin
        // shift register mode keeps the ninth bit flag untouched
        load9_d = 1'b0;
      end
      2'b01: begin
        if (!multiproc_enable) begin
          load9_d = 1'b1;
          val9_d = rx_stop;
        end else begin
          accept_d = rx_stop;
        end
      end
      2'b10, 2'b11: begin
        load9_d = 1'b1;
        val9_d = rx_bit9;
        if (multiproc_enable) begin
          accept_d = rx_bit9 & addr_match;
        end
      end
      default: begin
        load9_d = 1'b0;
      end
    endcase
  end
  always @(posedge clk) begin
    if (!resetn) begin
      rx_accept_q <= 1'b0;
      rx_bad_stop_q <= 1'b0;
      rx_load9_q <= 1'b0;
      rx_val9_q <= 1'b0;
      rx_data_q <= 8'h00;
    end else begin
      rx_accept_q <= rx_done & accept_d;
      // stop checking only exists in the asynchronous modes
      rx_bad_stop_q <= rx_done & ~rx_stop & (mode != 2'b00);
      rx_load9_q <= rx_done & accept_d & load9_d;
      rx_val9_q <= val9_d;
      if (rx_done & accept_d) begin
        rx_data_q <= rx_byte;
      end
    end
  end
endmodule
`default_nettype wire

/* usc_serial_ctrl.v */
// serial port control/status registers with an AHB-Lite slave and interrupt
`include "usc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module usc_serial_ctrl (
  // clock and reset
  input wire clk,
  input wire resetn,
  // ahb-lite slave
  input wire hsel,
  // byte address: a register's index from the map times four, one word each
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // shift engine: transmit side
  input wire tx_bit8_end,
  input wire tx_stop_start,
  output wire tx_ninth_bit_out,
  // shift engine: receive side
  input wire rx_last_data,
  input wire rx_done,
  input wire [7:0] rx_byte,
  input wire rx_bit9,
  input wire rx_stop,
  // mode outputs
  output wire [1:0] serial_mode,
  output wire rx_enable,
  output wire framing_detect,
  // interrupt
  output wire irq
);
  // control register fields
  reg framing_error_flag_q;
  reg mode_select_hi_q;
  reg mode_select_lo_q;
  reg multiproc_enable_q;
  reg rx_en_q;
  reg tx_ninth_bit_q;
  reg rx_ninth_bit_q;
  reg tx_irq_flag_q;
  reg rx_irq_flag_q;
  reg [7:0] slave_address_q;
  reg [7:0] slave_address_mask_q;
  reg framing_access_select_q;
  reg [`USC_IRQ_W-1:0] irq_stat_q;
  reg [`USC_IRQ_W-1:0] irq_en_q;
  // bus pipeline
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg rx_last_q;
  wire addr_phase;
  wire [7:0] ctrl_rd;
  wire [7:0] wdata;
  wire wr_ctrl;
  wire wr_slave_address;
  wire wr_smask;
  wire wr_facc;
  wire wr_ien;
  wire wr_iclr;
  wire [1:0] mode;
  wire addr_match;
  wire rx_accept;
  wire rx_bad_stop;
  wire rx_load9;
  wire rx_val9;
  wire [7:0] rx_data;
  wire tx_set;
  wire rx_set;
  wire [`USC_IRQ_W-1:0] irq_events;
  reg [31:0] rd_d;

  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdata = hwdata[7:0];
  // each writable register has its own write strobe; a control write loads all bits at once, the top one
  // into the framing flag or mode hi by the access select; the slave address only ever takes a whole byte
  assign wr_ctrl = wr_pend_q & (wr_addr_q == `USC_OFF_CTRL);
  assign wr_slave_address = wr_pend_q & (wr_addr_q == `USC_OFF_SLAVE_ADDRESS);
  assign wr_smask = wr_pend_q & (wr_addr_q == `USC_OFF_SMASK);
  assign wr_facc = wr_pend_q & (wr_addr_q == `USC_OFF_FACC);
  assign wr_ien = wr_pend_q & (wr_addr_q == `USC_OFF_IRQ_EN);
  assign wr_iclr = wr_pend_q & (wr_addr_q == `USC_OFF_IRQ_CLR);

  // mode decode: 00 shift, 01 8-bit var, 10 9-bit fixed, 11 9-bit var
  assign mode = {mode_select_hi_q, mode_select_lo_q};
  assign serial_mode = mode;
  assign rx_enable = rx_en_q;
  assign framing_detect = framing_access_select_q;
  // ninth data bit goes out in modes 2 and 3 only
  assign tx_ninth_bit_out = mode[1] & tx_ninth_bit_q;

  usc_addr_match u_match (
    .slave_address(slave_address_q),
    .slave_address_mask(slave_address_mask_q),
    .rx_byte(rx_byte),
    .match(addr_match)
  );

  // frames are ignored while reception is disabled
  usc_rx_frame u_rx (
    .clk(clk),
    .resetn(resetn),
    .rx_done(rx_done & rx_en_q),
    .rx_byte(rx_byte),
    .rx_bit9(rx_bit9),
    .rx_stop(rx_stop),
    .mode(mode),
    .multiproc_enable(multiproc_enable_q),
    .addr_match(addr_match),
    .rx_accept_q(rx_accept),
    .rx_bad_stop_q(rx_bad_stop),
    .rx_load9_q(rx_load9),
    .rx_val9_q(rx_val9),
    .rx_data_q(rx_data)
  );

  // tx flag events per mode
  assign tx_set = (mode == 2'b00) ? tx_bit8_end : tx_stop_start;
  // with framing detection, and in shift mode, the rx flag sets on the accept pulse;
  // otherwise it sets one cycle later, from the accept pulse registered once
  assign rx_set = (framing_access_select_q | (mode == 2'b00)) ? rx_accept : rx_last_q;
  assign irq_events = {rx_bad_stop, rx_set, tx_set};

  // top bit shows framing flag or mode hi by the access select
  assign ctrl_rd = {framing_access_select_q ? framing_error_flag_q : mode_select_hi_q,
    mode_select_lo_q, multiproc_enable_q, rx_en_q, tx_ninth_bit_q,
    rx_ninth_bit_q, tx_irq_flag_q, rx_irq_flag_q};

  always @(posedge clk) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rx_last_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr[9:2];
      end
      // accept pulse delayed by one cycle, used as the non-framing rx flag event
      rx_last_q <= rx_accept;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      framing_error_flag_q <= 1'b0;
      mode_select_hi_q <= 1'b0;
      mode_select_lo_q <= 1'b0;
      multiproc_enable_q <= 1'b0;
      rx_en_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
      rx_ninth_bit_q <= 1'b0;
      tx_irq_flag_q <= 1'b0;
      rx_irq_flag_q <= 1'b0;
      slave_address_q <= `USC_RST_SLAVE_ADDRESS;
      slave_address_mask_q <= `USC_RST_SMASK;
      framing_access_select_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        if (framing_access_select_q) begin
          framing_error_flag_q <= wdata[`USC_BIT_TOP];
        end else begin
          mode_select_hi_q <= wdata[`USC_BIT_TOP];
        end
        mode_select_lo_q <= wdata[`USC_BIT_MODE_LO];
        multiproc_enable_q <= wdata[`USC_BIT_MP];
        rx_en_q <= wdata[`USC_BIT_REN];
        tx_ninth_bit_q <= wdata[`USC_BIT_TB8];
        rx_ninth_bit_q <= wdata[`USC_BIT_RB8];
        tx_irq_flag_q <= wdata[`USC_BIT_TI];
        rx_irq_flag_q <= wdata[`USC_BIT_RI];
      end
      // hardware sets win over a software write in the same cycle
      if (rx_bad_stop) begin
        framing_error_flag_q <= 1'b1;
      end
      if (rx_load9) begin
        rx_ninth_bit_q <= rx_val9;
      end
      if (tx_set) begin
        tx_irq_flag_q <= 1'b1;
      end
      if (rx_set) begin
        rx_irq_flag_q <= 1'b1;
      end
      if (wr_slave_address) begin
        slave_address_q <= wdata;
      end
      if (wr_smask) begin
        slave_address_mask_q <= wdata;
      end
      if (wr_facc) begin
        framing_access_select_q <= wdata[0];
      end
    end
  end

  // sticky interrupt status: set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < `USC_IRQ_W; gi = gi + 1) begin : g_irq
      always @(posedge clk) begin
        if (!resetn) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_events[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (wr_iclr & wdata[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!resetn) begin
      irq_en_q <= {`USC_IRQ_W{1'b0}};
    end else if (wr_ien) begin
      irq_en_q <= wdata[`USC_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // read data registered in the address phase, valid in the data phase
  always @* begin
    rd_d = 32'h00000000;
    case (haddr[9:2])
      `USC_OFF_CTRL: rd_d = {24'h000000, ctrl_rd};
      `USC_OFF_SLAVE_ADDRESS: rd_d = {24'h000000, slave_address_q};
      `USC_OFF_SMASK: rd_d = {24'h000000, slave_address_mask_q};
      `USC_OFF_FACC: rd_d = {31'h00000000, framing_access_select_q};
      `USC_OFF_IRQ_STAT: rd_d = {29'h00000000, irq_stat_q};
      `USC_OFF_IRQ_EN: rd_d = {29'h00000000, irq_en_q};
      `USC_OFF_RXDATA: rd_d = {24'h000000, rx_data};
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= rd_d;
    end
  end
endmodule
`default_nettype wire

/* usc_stn.sv */
// remote station model: frame and transmit events toward the block
`timescale 1ns/1ps
`default_nettype none
module usc_stn (
  // clock
  input wire clk,
  // transmit events
  output logic tx_bit8_end,
  output logic tx_stop_start,
  // received frame
  output logic rx_last_data,
  output logic rx_done,
  output logic [7:0] rx_byte,
  output logic rx_bit9,
  output logic rx_stop
);
  initial {tx_bit8_end, tx_stop_start, rx_last_data, rx_done, rx_byte, rx_bit9, rx_stop} = 14'h0;
  // lines hold the frame only with rx_done, then show its inverse
  task automatic frame(input logic [7:0] b, input logic b9, input logic st);
    @(posedge clk);
    rx_last_data <= 1'b1;
    @(posedge clk);
    {rx_last_data, rx_done, rx_byte, rx_bit9, rx_stop} <= {2'h1, b, b9, st};
    @(posedge clk);
    {rx_done, rx_byte, rx_bit9, rx_stop} <= {1'b0, ~b, ~b9, ~st};
  endtask
  task automatic tx_end(input logic sb);
    @(posedge clk);
    {tx_bit8_end, tx_stop_start} <= {~sb, sb};
    @(posedge clk);
    {tx_bit8_end, tx_stop_start} <= 2'h0;
  endtask
endmodule
`default_nettype wire
